// >>> include/abu_pkg.sv
// Shared constants and types of the address breakpoint unit
package abu_pkg;

   // ---------------------------------------------------------------
   // Register byte offsets on the Avalon-MM slave
   // ---------------------------------------------------------------
   localparam logic [4:0] OFF_CTRL      = 5'h00;   // break_control_status
   localparam logic [4:0] OFF_ADDR_HIGH = 5'h04;   // break_addr_high
   localparam logic [4:0] OFF_ADDR_LOW  = 5'h08;   // break_addr_low
   localparam logic [4:0] OFF_IRQ_STAT  = 5'h0C;   // Sticky event bits, write one to clear
   localparam logic [4:0] OFF_IRQ_MASK  = 5'h10;   // Event mask, same layout
   localparam logic [4:0] OFF_SIM_CTRL  = 5'h14;   // sim_break_flag_control
   localparam logic [4:0] OFF_WAIT_STAT = 5'h18;   // Wait exit record, write one to clear

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int BIT_ENABLE     = 7;              // break_enable_bit
   localparam int BIT_ACTIVE     = 6;              // break_active_flag
   localparam int BIT_FLAG_CLEAR = 7;              // flag_clear_in_break_enable
   localparam int BIT_WAIT_EXIT  = 0;              // wait_exit_by_break
   localparam int IRQ_MATCH      = 0;              // Address match break
   localparam int IRQ_SOFT       = 1;              // Software requested break
   localparam int IRQ_END        = 2;              // Break ended by return
   localparam int IRQ_W          = 3;              // Event count

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0]       RST_BYTE = 8'h00;  // All break registers clear
   localparam logic [IRQ_W-1:0] RST_IRQ  = 3'h0;   // No events, all masked

   // ---------------------------------------------------------------
   // Break handler vectors (high byte address, low byte follows)
   // ---------------------------------------------------------------
   localparam logic [15:0] VEC_USER    = 16'hFFFC;
   localparam logic [15:0] VEC_MONITOR = 16'hFEFC;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0]
   {
      ST_IDLE  = 3'b001,                           // Normal operation
      ST_PEND  = 3'b010,                           // Waiting for instruction end
      ST_BREAK = 3'b100                            // Break routine running
   } abu_state_t;

   typedef struct packed
   {
      logic [15:0] addr;                           // Internal address bus
      logic        from_pc;                        // Address comes from program counter
      logic        last_cycle;                     // Last cycle of current instruction
      logic        rti_done;                       // Return from interrupt executed
   } abu_cpu_t;

endpackage

// >>> rtl/abu_cmp.sv
// Breakpoint address comparator
`timescale 1ns/10ps
module abu_cmp
(
   cpu,
   brk_addr,
   enable,
   stop_mode,
   match
);
   input  wire abu_pkg::abu_cpu_t cpu;             // CPU bus view
   input  wire logic [15:0]       brk_addr;        // Programmed address
   input  wire logic              enable;          // Break enable bit
   input  wire logic              stop_mode;       // Unit inactive in stop
   output logic                   match;           // Qualified match

   // ---------------------------------------------------------------
   // Compare only program counter addresses; other masters are ignored
   // ---------------------------------------------------------------
   always_comb
   begin
      match = enable && cpu.from_pc && !stop_mode && (cpu.addr == brk_addr);
   end

endmodule

// >>> rtl/abu_top.sv
// Address breakpoint unit with Avalon-MM register slave
//
// How it works
// - Enabled address match raises breakpoint request
// - Opcode forced after current instruction completes
// - Vector FFFC user, FEFC monitor mode
// - Only program counter addresses are compared
// - Software writing active flag forces break
// - Return from interrupt ends break state
// - Match on last cycle breaks immediately
// - Timer halted while break state active
// - Watchdog off in break with high voltage
// - Enable bit seven, cleared by zero, reset
// - Match sets active flag; software clears it
// - Status clears in break need clear enable
// - Two address byte registers, reset clears both
// - Works in wait; records wait exit by break
// - Address matching inactive in stop; registers keep contents
`timescale 1ns/10ps
module abu_top
#(
   parameter logic [7:0] SOFT_INTERRUPT_OPCODE = 8'h00  // Plain default, set per core
)
(
   ref_clk,
   rst_n,
   avs_address,
   avs_read,
   avs_write,
   avs_byteenable,
   avs_writedata,
   avs_readdata,
   avs_waitrequest,
   cpu,
   monitor_mode,
   high_voltage_level,
   wait_mode,
   stop_mode,
   breakpoint_request,
   force_opcode,
   soft_interrupt_opcode,
   vector_addr,
   timer_halt,
   watchdog_disable,
   status_clear_allowed,
   irq
);
   input  wire logic              ref_clk;               // 50 MHz bus clock
   input  wire logic              rst_n;                 // Synchronous reset
   input  wire logic [4:0]        avs_address;           // Byte address
   input  wire logic              avs_read;              // Read request
   input  wire logic              avs_write;             // Write request
   input  wire logic [3:0]        avs_byteenable;        // Only lane 0 used
   input  wire logic [31:0]       avs_writedata;         // Write data
   output logic [31:0]            avs_readdata;          // Read data
   output logic                   avs_waitrequest;       // Stall
   input  wire abu_pkg::abu_cpu_t cpu;                   // CPU bus view
   input  wire logic              monitor_mode;          // Alternate vectors
   input  wire logic              high_voltage_level;    // High level on reset pin
   input  wire logic              wait_mode;             // CPU in wait
   input  wire logic              stop_mode;             // CPU in stop
   output logic                   breakpoint_request;    // Pulse to integration unit
   output logic                   force_opcode;          // Pulse: load opcode
   output logic [7:0]             soft_interrupt_opcode; // Opcode to load
   output logic [15:0]            vector_addr;           // Handler vector high byte
   output logic                   timer_halt;            // Stop timer counter
   output logic                   watchdog_disable;      // Suppress watchdog
   output logic                   status_clear_allowed;  // Module flags clearable
   output logic                   irq;                   // Level interrupt

   // ---------------------------------------------------------------
   // Registers and state
   // ---------------------------------------------------------------
   logic                   enable_q;                     // break_enable_bit
   logic                   active_q;                     // break_active_flag
   logic [7:0]             addr_high_q;                  // break_addr_high
   logic [7:0]             addr_low_q;                   // break_addr_low
   logic                   flag_clear_q;                 // flag_clear_in_break_enable
   logic                   wait_exit_q;                  // wait_exit_by_break
   logic [abu_pkg::IRQ_W-1:0] irq_stat_q;                // Sticky events
   logic [abu_pkg::IRQ_W-1:0] irq_mask_q;                // Event mask
   abu_pkg::abu_state_t    state_q;                      // Break sequencer
   abu_pkg::abu_state_t    state_d;                      // Next state
   logic                   wait_q;                       // Waitrequest flop
   logic [31:0]            rdata_q;                      // Read data flop
   logic                   breakpoint_request_q;                       // Request flop
   logic                   force_q;                      // Opcode strobe flop
   logic [15:0]            vec_q;                        // Vector flop
   logic                   halt_q;                       // Timer halt flop
   logic                   wdog_q;                       // Watchdog off flop
   logic                   clr_ok_q;                     // Clear allowed flop
   logic                   irq_q;                        // Interrupt flop

   logic                   match_w;                      // Qualified address match
   logic                   acc_w;                        // Access completes now
   logic                   wr_w;                         // Write completes now
   logic                   sw_set_w;                     // Software break request
   logic                   trigger_w;                    // Any break cause
   logic                   rti_w;                        // Break end event

   // ---------------------------------------------------------------
   // Decode helper
   // ---------------------------------------------------------------
   function automatic logic sel(input logic [4:0] a, input logic [4:0] off);
      sel = (a == off);
   endfunction

   // ---------------------------------------------------------------
   // Comparator
   // ---------------------------------------------------------------
   abu_cmp u_cmp
   (
      .cpu       (cpu),
      .brk_addr  ({addr_high_q, addr_low_q}),
      .enable    (enable_q),
      .stop_mode (stop_mode),
      .match     (match_w)
   );

   // Access completes on the edge where waitrequest is seen low
   assign acc_w     = (avs_read || avs_write) && !wait_q;
   assign wr_w      = acc_w && avs_write && avs_byteenable[0];
   assign sw_set_w  = wr_w && sel(avs_address, abu_pkg::OFF_CTRL)
                      && avs_writedata[abu_pkg::BIT_ACTIVE];
   assign trigger_w = match_w || sw_set_w;
   assign rti_w     = (state_q == abu_pkg::ST_BREAK) && cpu.rti_done;

   // ---------------------------------------------------------------
   // Bus handshake: one wait cycle, then a single completion cycle
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         wait_q <= 1'b1;
      end
      else if ((avs_read || avs_write) && wait_q)
      begin
         wait_q <= 1'b0;                                 // Answer next cycle
      end
      else
      begin
         wait_q <= 1'b1;                                 // Idle or just completed
      end
   end

   // Read data is settled one cycle early so it stands at completion
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         rdata_q <= 32'h0000_0000;
      end
      else if (avs_read && wait_q)
      begin
         rdata_q <= 32'h0000_0000;                       // Unmapped reads as zero
         if (sel(avs_address, abu_pkg::OFF_CTRL))
         begin
            rdata_q[abu_pkg::BIT_ENABLE] <= enable_q;
            rdata_q[abu_pkg::BIT_ACTIVE] <= active_q;
         end
         else if (sel(avs_address, abu_pkg::OFF_ADDR_HIGH))
         begin
            rdata_q[7:0] <= addr_high_q;
         end
         else if (sel(avs_address, abu_pkg::OFF_ADDR_LOW))
         begin
            rdata_q[7:0] <= addr_low_q;
         end
         else if (sel(avs_address, abu_pkg::OFF_IRQ_STAT))
         begin
            rdata_q[abu_pkg::IRQ_W-1:0] <= irq_stat_q;
         end
         else if (sel(avs_address, abu_pkg::OFF_IRQ_MASK))
         begin
            rdata_q[abu_pkg::IRQ_W-1:0] <= irq_mask_q;
         end
         else if (sel(avs_address, abu_pkg::OFF_SIM_CTRL))
         begin
            rdata_q[abu_pkg::BIT_FLAG_CLEAR] <= flag_clear_q;
         end
         else if (sel(avs_address, abu_pkg::OFF_WAIT_STAT))
         begin
            rdata_q[abu_pkg::BIT_WAIT_EXIT] <= wait_exit_q;
         end
      end
   end

   // ---------------------------------------------------------------
   // Control bits; stop leaves every register untouched
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         enable_q     <= 1'b0;
         addr_high_q  <= abu_pkg::RST_BYTE;
         addr_low_q   <= abu_pkg::RST_BYTE;
         flag_clear_q <= 1'b0;
         irq_mask_q   <= abu_pkg::RST_IRQ;
      end
      else if (wr_w)
      begin
         if (sel(avs_address, abu_pkg::OFF_CTRL))
         begin
            enable_q <= avs_writedata[abu_pkg::BIT_ENABLE];
         end
         else if (sel(avs_address, abu_pkg::OFF_ADDR_HIGH))
         begin
            addr_high_q <= avs_writedata[7:0];
         end
         else if (sel(avs_address, abu_pkg::OFF_ADDR_LOW))
         begin
            addr_low_q <= avs_writedata[7:0];
         end
         else if (sel(avs_address, abu_pkg::OFF_IRQ_MASK))
         begin
            irq_mask_q <= avs_writedata[abu_pkg::IRQ_W-1:0];
         end
         else if (sel(avs_address, abu_pkg::OFF_SIM_CTRL))
         begin
            flag_clear_q <= avs_writedata[abu_pkg::BIT_FLAG_CLEAR];
         end
      end
   end

   // Active flag: a match in the clearing cycle wins over the clear
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         active_q <= 1'b0;
      end
      else if (match_w || sw_set_w)
      begin
         active_q <= 1'b1;
      end
      else if (wr_w && sel(avs_address, abu_pkg::OFF_CTRL))
      begin
         active_q <= 1'b0;
      end
   end

   // Wait exit record, set wins over write-one clear
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         wait_exit_q <= 1'b0;
      end
      else if (wait_mode && trigger_w)
      begin
         wait_exit_q <= 1'b1;
      end
      else if (wr_w && sel(avs_address, abu_pkg::OFF_WAIT_STAT)
               && avs_writedata[abu_pkg::BIT_WAIT_EXIT])
      begin
         wait_exit_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Interrupt status and output
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         irq_stat_q <= abu_pkg::RST_IRQ;
      end
      else
      begin
         for (int i = 0; i < abu_pkg::IRQ_W; i++)
         begin
            if ((i == abu_pkg::IRQ_MATCH && match_w) ||
                (i == abu_pkg::IRQ_SOFT && sw_set_w) ||
                (i == abu_pkg::IRQ_END && rti_w))
            begin
               irq_stat_q[i] <= 1'b1;                    // Set wins
            end
            else if (wr_w && sel(avs_address, abu_pkg::OFF_IRQ_STAT) && avs_writedata[i])
            begin
               irq_stat_q[i] <= 1'b0;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Break sequencer
   // ---------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         abu_pkg::ST_IDLE:
         begin
            if (trigger_w)
            begin
               // Hazard: a match on the final cycle must not wait another instruction
               state_d = cpu.last_cycle ? abu_pkg::ST_BREAK : abu_pkg::ST_PEND;
            end
         end
         abu_pkg::ST_PEND:
         begin
            if (cpu.last_cycle)
            begin
               state_d = abu_pkg::ST_BREAK;
            end
         end
         abu_pkg::ST_BREAK:
         begin
            if (cpu.rti_done)
            begin
               state_d = abu_pkg::ST_IDLE;
            end
         end
         default:
         begin
            state_d = abu_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         state_q <= abu_pkg::ST_IDLE;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // Request and opcode strobes toward the integration unit
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         breakpoint_request_q  <= 1'b0;
         force_q <= 1'b0;
      end
      else
      begin
         breakpoint_request_q  <= trigger_w;
         force_q <= (state_q != abu_pkg::ST_BREAK) && (state_d == abu_pkg::ST_BREAK);
      end
   end

   // Vector and side effects of the break state
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         vec_q    <= abu_pkg::VEC_USER;
         halt_q   <= 1'b0;
         wdog_q   <= 1'b0;
         clr_ok_q <= 1'b1;
         irq_q    <= 1'b0;
      end
      else
      begin
         vec_q    <= monitor_mode ? abu_pkg::VEC_MONITOR : abu_pkg::VEC_USER;
         halt_q   <= (state_d == abu_pkg::ST_BREAK);
         wdog_q   <= (state_d == abu_pkg::ST_BREAK) && high_voltage_level;
         clr_ok_q <= (state_d != abu_pkg::ST_BREAK) || flag_clear_q;
         irq_q    <= |(irq_stat_q & irq_mask_q);
      end
   end

   assign avs_readdata          = rdata_q;
   assign avs_waitrequest       = wait_q;
   assign breakpoint_request    = breakpoint_request_q;
   assign force_opcode          = force_q;
   assign soft_interrupt_opcode = SOFT_INTERRUPT_OPCODE;
   assign vector_addr           = vec_q;
   assign timer_halt            = halt_q;
   assign watchdog_disable      = wdog_q;
   assign status_clear_allowed  = clr_ok_q;
   assign irq                   = irq_q;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   a_match_request: assert property (match_w |=> breakpoint_request)
      else $error("match without breakpoint request");
   a_force_at_end: assert property ($rose(force_opcode) |-> $past(cpu.last_cycle))
      else $error("opcode forced before instruction end");
   a_vector_select: assert property (##1 vector_addr == ($past(monitor_mode)
                                     ? 16'hFEFC : 16'hFFFC))
      else $error("wrong break vector");
   a_pc_only: assert property ((!cpu.from_pc && !sw_set_w) |=> !breakpoint_request)
      else $error("break from non program counter address");
   a_soft_break: assert property (sw_set_w |=> breakpoint_request && active_q)
      else $error("software break lost");
   a_rti_exit: assert property (rti_w |=> state_q == abu_pkg::ST_IDLE && !timer_halt)
      else $error("break not ended by return");
   a_last_cycle: assert property ((state_q == abu_pkg::ST_IDLE && trigger_w
                                   && cpu.last_cycle) |=> force_opcode)
      else $error("last cycle match delayed");
   a_timer_halt: assert property (##1 timer_halt == (state_q == abu_pkg::ST_BREAK))
      else $error("timer halt mismatch");
   a_watchdog_off: assert property (watchdog_disable |-> timer_halt)
      else $error("watchdog off outside break");
   a_enable_clear: assert property ((wr_w && sel(avs_address, abu_pkg::OFF_CTRL)
                                     && !avs_writedata[7]) |=> !enable_q)
      else $error("enable not cleared");
   a_active_set: assert property (match_w |=> active_q)
      else $error("active flag not set");
   a_clear_gate: assert property ((state_q == abu_pkg::ST_BREAK && !flag_clear_q
                                   && $stable(state_q) && !cpu.rti_done)
                                  |=> !status_clear_allowed)
      else $error("status clear allowed in break");
   a_stop_quiet: assert property (stop_mode |=> !breakpoint_request || $past(sw_set_w))
      else $error("break in stop");

   c_soft_break: cover property (sw_set_w ##1 breakpoint_request);
   c_pend_break: cover property (state_q == abu_pkg::ST_PEND ##[1:20] force_opcode);
   c_rti_exit:   cover property (force_opcode ##[1:50] rti_w);

endmodule

// >>> verification/abu_cpu_model.sv
// CPU bus model driving the breakpoint unit
`timescale 1ns/10ps
module abu_cpu_model
(
   ref_clk,
   cpu
);
   input  wire logic         ref_clk; // Bus clock
   output abu_pkg::abu_cpu_t cpu;     // Address bus view
   // ----------------------------------------------------------
   // One bus cycle, then the bus is released
   // ----------------------------------------------------------
   task automatic drive(input logic [15:0] a, input logic pc, input logic lst,
                        input logic return_from_interrupt_op);
      begin
         @(posedge ref_clk);
         cpu <= '{a, pc, lst, return_from_interrupt_op};
         @(posedge ref_clk);
         // Inverse address, so a stale value never matches by luck
         cpu <= '{~a, 1'b0, 1'b0, 1'b0};
      end
   endtask
   initial cpu = '0;
endmodule

// >>> verification/address_breakpoint_unit_bench.sv
// Self-checking bench of the address breakpoint unit
`timescale 1ns/10ps
module address_breakpoint_unit_bench;
   logic              ref_clk, rst_n, avs_read, avs_write, avs_waitrequest;
   logic              monitor_mode, high_voltage_level, stop_mode, irq, wait_mode;
   logic              breakpoint_request, force_opcode, timer_halt;
   logic              watchdog_disable, status_clear_allowed;
   logic [4:0]        avs_address;
   logic [7:0]        soft_interrupt_opcode;
   logic [15:0]       vector_addr;
   logic [31:0]       avs_writedata, avs_readdata, rd;
   abu_pkg::abu_cpu_t cpu;
   int                failures, total_checks;
   abu_top u_dut (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write,
      .avs_byteenable(4'hF), .avs_writedata, .avs_readdata, .avs_waitrequest,
      .cpu, .monitor_mode, .high_voltage_level, .wait_mode, .stop_mode,
      .breakpoint_request, .force_opcode, .soft_interrupt_opcode, .vector_addr,
      .timer_halt, .watchdog_disable, .status_clear_allowed, .irq);
   abu_cpu_model u_cpu (.ref_clk, .cpu);
   // ----------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      begin
         total_checks++;
         if (got !== exp)
         begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   // Avalon access, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
      begin
         @(posedge ref_clk);
         avs_write     <= w;
         avs_read      <= !w;
         avs_address   <= a;
         avs_writedata <= {24'h0, d};
         do
            @(posedge ref_clk);
         while (avs_waitrequest);
         rd = avs_readdata;
         avs_write <= 1'b0;
         avs_read  <= 1'b0;
      end
   endtask
   task automatic close_out;
      begin
         $display("checks %0d failures %0d", total_checks, failures);
         if (failures == 0 && total_checks > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   // ----------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------
   task automatic t_reset;
      begin
         bus(1'b0, abu_pkg::OFF_CTRL, 8'h00);
         chk("ctrl", rd, 32'h0);
         bus(1'b0, abu_pkg::OFF_ADDR_HIGH, 8'h00);
         chk("high", rd, 32'h0);
         bus(1'b0, abu_pkg::OFF_ADDR_LOW, 8'h00);
         chk("low", rd, 32'h0);
         bus(1'b0, 5'h1C, 8'h00);
         chk("unmapped", rd, 32'h0);
         chk("vector", {16'h0, vector_addr}, {16'h0, abu_pkg::VEC_USER});
      end
   endtask
   task automatic t_match;
      begin
         bus(1'b1, abu_pkg::OFF_ADDR_HIGH, 8'h12);
         bus(1'b1, abu_pkg::OFF_ADDR_LOW, 8'h34);
         bus(1'b1, abu_pkg::OFF_IRQ_MASK, 8'h07);
         bus(1'b1, abu_pkg::OFF_CTRL, 8'h80);
         u_cpu.drive(16'h1234, 1'b0, 1'b0, 1'b0);
         stop_mode <= 1'b1;
         #1 chk("nonpc", {31'h0, breakpoint_request}, 32'h0);
         u_cpu.drive(16'h1234, 1'b1, 1'b0, 1'b0);
         stop_mode <= 1'b0;
         #1 chk("stop", {31'h0, breakpoint_request}, 32'h0);
         u_cpu.drive(16'h1234, 1'b1, 1'b0, 1'b0);
         #1 chk("req", {31'h0, breakpoint_request}, 32'h1);
         chk("early", {31'h0, force_opcode}, 32'h0);
         u_cpu.drive(16'h0000, 1'b0, 1'b1, 1'b0);
         #1 chk("force", {31'h0, force_opcode}, 32'h1);
         chk("halt", {31'h0, timer_halt}, 32'h1);
         bus(1'b0, abu_pkg::OFF_CTRL, 8'h00);
         chk("active", rd, 32'hC0);
         chk("irq", {31'h0, irq}, 32'h1);
         chk("wdog", {31'h0, watchdog_disable}, 32'h1);
         chk("noclr", {31'h0, status_clear_allowed}, 32'h0);
         bus(1'b1, abu_pkg::OFF_SIM_CTRL, 8'h80);
         @(posedge ref_clk);
         #1 chk("clr", {31'h0, status_clear_allowed}, 32'h1);
         u_cpu.drive(16'h0000, 1'b0, 1'b0, 1'b1);
         high_voltage_level <= 1'b0;
         @(posedge ref_clk);
         #1 chk("unhalt", {31'h0, timer_halt}, 32'h0);
         u_cpu.drive(16'h1234, 1'b1, 1'b1, 1'b0);
         #1 chk("lastcyc", {31'h0, force_opcode}, 32'h1);
         chk("wdog_lo", {31'h0, watchdog_disable}, 32'h0);
         u_cpu.drive(16'h0000, 1'b0, 1'b0, 1'b1);
         bus(1'b0, abu_pkg::OFF_IRQ_STAT, 8'h00);
         chk("ended", rd, 32'h5);
         bus(1'b1, abu_pkg::OFF_CTRL, 8'h9F);
         bus(1'b0, abu_pkg::OFF_CTRL, 8'h00);
         chk("swclr", rd, 32'h80);
         bus(1'b1, abu_pkg::OFF_IRQ_STAT, 8'h07);
         bus(1'b1, abu_pkg::OFF_CTRL, 8'h00);
         chk("irqoff", {31'h0, irq}, 32'h0);
      end
   endtask
   task automatic t_soft;
      begin
         bus(1'b1, abu_pkg::OFF_IRQ_MASK, 8'h01);
         wait_mode <= 1'b1;
         bus(1'b1, abu_pkg::OFF_CTRL, 8'h40);
         wait_mode <= 1'b0;
         bus(1'b0, abu_pkg::OFF_IRQ_STAT, 8'h00);
         chk("soft", rd, 32'h2);
         chk("masked", {31'h0, irq}, 32'h0);
         bus(1'b0, abu_pkg::OFF_WAIT_STAT, 8'h00);
         chk("waitexit", rd, 32'h1);
         bus(1'b1, abu_pkg::OFF_WAIT_STAT, 8'h01);
         bus(1'b0, abu_pkg::OFF_WAIT_STAT, 8'h00);
         chk("waitclr", rd, 32'h0);
         bus(1'b1, abu_pkg::OFF_IRQ_MASK, 8'h02);
         @(posedge ref_clk);
         monitor_mode <= 1'b1;
         #1 chk("unmask", {31'h0, irq}, 32'h1);
         repeat (2) @(posedge ref_clk);
         #1 chk("monvec", {16'h0, vector_addr}, {16'h0, abu_pkg::VEC_MONITOR});
      end
   endtask
   // ----------------------------------------------------------
   // Clock, reset, sequence and watchdog
   // ----------------------------------------------------------
   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   initial
   begin
      {rst_n, avs_read, avs_write, monitor_mode, stop_mode, wait_mode} = '0;
      {avs_address, avs_writedata, failures, total_checks} = '0;
      high_voltage_level = 1'b1;
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_reset;
      t_match;
      t_soft;
      close_out;
   end
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      close_out;
   end
endmodule
